//--- fcsr_regs.vh
// register map, field positions and reset values of the flash command and status block
`ifndef FCSR_REGS_VH
`define FCSR_REGS_VH
`define FCSR_OFF_CONFIG   4'h0
`define FCSR_OFF_PROT     4'h4
`define FCSR_OFF_STATUS   4'h8
`define FCSR_OFF_CMD      4'hc
`define FCSR_OFF_DIVIDER  5'h10
`define FCSR_OFF_ARRAY    5'h14
`define FCSR_OFF_SECURE   5'h18
`define FCSR_CFG_MASK     8'he0
`define FCSR_CFG_KEYEN    5
`define FCSR_ST_BUFEMPTY  7
`define FCSR_ST_COMPLETE  6
`define FCSR_ST_PVIOL     5
`define FCSR_ST_ACCERR    4
`define FCSR_ST_BLANK     2
`define FCSR_DIV_LOADED   7
`define FCSR_CMD_BLANK    8'h05
`define FCSR_CMD_BYTE     8'h20
`define FCSR_CMD_BURST    8'h25
`define FCSR_CMD_PAGE     8'h40
`define FCSR_CMD_MASS     8'h41
`define FCSR_KEY_FIRST    16'hffb0
`define FCSR_KEY_LAST     16'hffb7
`define FCSR_SEC_UNSEC    2'b10
`define FCSR_SEC_RESET    2'b00
`define FCSR_ST_RESET     8'hc0
`define FCSR_OKAY         2'b00
`define FCSR_SLVERR       2'b10
`define FCSR_PAGE_BYTES   16'h0200
`endif

//--- fcsr_exec.v
// command execution timer: runs a launched command for a fixed number of cycles
`timescale 1ns/1ps
`include "fcsr_regs.vh"
module fcsr_exec #(
    parameter CYCLES = 16
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       start,
    input  wire       abort,
    output reg        busy_ff,
    output reg        done_ff
);
    reg  [15:0] cnt_ff;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 16'h0000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (abort) begin
                busy_ff <= 1'b0;
                cnt_ff  <= 16'h0000;
            end else if (start) begin
                busy_ff <= 1'b1;
                cnt_ff  <= CYCLES[15:0];
            end else if (busy_ff) begin
                if (cnt_ff <= 16'h0001) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
                cnt_ff <= cnt_ff - 16'h0001;
            end
        end
    end
endmodule

//--- fcsr_top.v
// flash command, status, protection and configuration registers behind AXI4-Lite
// Function
// - config bits 7:5 read/write; bits 4:0 read zero, writes ignored
// - key enable 0 makes key-address writes command starts; 1 makes them key writes
// - protection register loaded from nonvolatile byte at reset, always readable
// - with disable 0 writes may only lower select value; with 1 no change
// - debug access may change every protection bit freely
// - select field bits 7:1 set end of unprotected low region; refuse protected
// - disable bit 0 protects selected block; 1 protects nothing
// - status bits 3,1,0 read zero, writes ignored
// - writing 1 to buffer-empty flag launches command, device clears flag
// - buffer-empty sets as a burst or a parked command moves to array; other launches hold it clear until done
// - complete flag set when buffer empty and idle; cleared on valid launch
// - protection violation set on protected target, command ignored; write 1 clears
// - access error on bad sequence, no divider, or stop mid-command; write 1 clears
// - blank flag set after blank check of erased array; cleared on valid launch
// - code 05 is blank check, code 41 is mass erase
// - code 20 is byte program, code 25 is burst byte program
// - code 40 is page erase of 512 bytes
// - every other code is illegal and sets access error
// - divider loaded flag 0 until first divider write; program/erase disabled meanwhile
// - successful blank check or key entry sets security code to unsecured
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "fcsr_regs.vh"
module fcsr_top #(
    parameter EXEC_CYCLES = 16
) (
    input  wire        SYS_CLK,
    input  wire        RESETN,
    input  wire [7:0]  NONVOLATILE_PROTECTION_BYTE_BYTE,
    input  wire        BDM_PROT_WE,
    input  wire [7:0]  BDM_PROT_DATA,
    input  wire        ARRAY_WE,
    input  wire [15:0] ARRAY_ADDR,
    input  wire        ARRAY_ERASED,
    input  wire        KEY_MATCH,
    input  wire        STOP_REQ,
    output wire        KEY_WRITE,
    output wire        CMD_BUSY,
    output wire [7:0]  CMD_CODE,
    output wire [15:0] CMD_ADDR,
    output wire [1:0]  SEC_STATE,
    input  wire [4:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    output wire [1:0]  S_AXI_BRESP,
    output wire        S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [4:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0]  S_AXI_RRESP,
    output wire        S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);
    reg  [4:0]  awaddr_ff;
    reg         aw_have_ff;
    reg  [31:0] wdata_ff;
    reg         w_lane0_ff;
    reg         w_have_ff;
    reg         bvalid_ff;
    reg  [1:0]  bresp_ff;
    reg         rvalid_ff;
    reg  [31:0] rdata_ff;
    reg  [1:0]  rresp_ff;
    reg  [7:0]  cfg_ff;
    reg  [7:0]  prot_ff;
    reg         prot_loaded_ff;
    reg  [7:0]  cmd_ff;
    reg  [7:0]  run_cmd_ff;
    reg  [15:0] run_addr_ff;
    reg         bufempty_ff;
    reg         complete_ff;
    reg         pviol_ff;
    reg         accerr_ff;
    reg         blank_ff;
    reg         div_loaded_ff;
    reg  [7:0]  div_ff;
    reg  [1:0]  sec_ff;
    reg  [1:0]  seq_ff;
    reg  [15:0] seq_addr_ff;
    reg         pend_ff;
    reg  [7:0]  pend_cmd_ff;
    reg  [15:0] pend_addr_ff;
    reg  [1:0]  stop_sync_ff;
    reg  [1:0]  erased_sync_ff;
    reg         key_sync_ff;
    reg         key_meta_ff;
    wire        exec_busy;
    wire        exec_done;
    // command sequence: array write, command write, launch
    localparam SEQ_IDLE = 2'b00;
    localparam SEQ_DATA = 2'b01;
    localparam SEQ_CMD  = 2'b10;
    localparam SEQ_GO   = 2'b11;
    // register writes land once address and data are both held
    wire        wr_go    = aw_have_ff && w_have_ff && !bvalid_ff;
    wire        wr_cfg   = wr_go && w_lane0_ff && awaddr_ff[4:2] == `FCSR_OFF_CONFIG >> 2;
    wire        wr_prot  = wr_go && w_lane0_ff && awaddr_ff[4:2] == `FCSR_OFF_PROT >> 2;
    wire        wr_stat  = wr_go && w_lane0_ff && awaddr_ff[4:2] == `FCSR_OFF_STATUS >> 2;
    wire        wr_cmd   = wr_go && w_lane0_ff && awaddr_ff[4:2] == `FCSR_OFF_CMD >> 2;
    wire        wr_div   = wr_go && w_lane0_ff && awaddr_ff == `FCSR_OFF_DIVIDER;
    wire        wr_known = awaddr_ff[4:2] <= (`FCSR_OFF_SECURE >> 2);
    wire        keyen    = cfg_ff[`FCSR_CFG_KEYEN];
    wire        in_key   = ARRAY_ADDR >= `FCSR_KEY_FIRST && ARRAY_ADDR <= `FCSR_KEY_LAST;
    wire        launch   = wr_stat && wdata_ff[`FCSR_ST_BUFEMPTY] && bufempty_ff;
    wire        arr_cmd  = ARRAY_WE && !(keyen && in_key);
    wire        stop_s   = stop_sync_ff[1];
    wire        cmd_legal = cmd_ff == `FCSR_CMD_BLANK || cmd_ff == `FCSR_CMD_BYTE ||
                            cmd_ff == `FCSR_CMD_BURST || cmd_ff == `FCSR_CMD_PAGE ||
                            cmd_ff == `FCSR_CMD_MASS;
    wire        is_pe     = cmd_ff != `FCSR_CMD_BLANK;
    wire        is_mass   = cmd_ff == `FCSR_CMD_MASS;
    // page erase is judged by the base of its page
    wire [15:0] page_base = seq_addr_ff & ~(`FCSR_PAGE_BYTES - 16'h0001);
    // everything above this end is protected while disable is 0
    wire [15:0] unprot_end = {prot_ff[7:1], 9'h1ff};
    wire        prot_hit  = !prot_ff[0] && is_pe &&
                            (is_mass || (cmd_ff == `FCSR_CMD_PAGE ? page_base : seq_addr_ff)
                             > unprot_end);
    // launch checks; exactly one outcome per launch
    wire        seq_bad   = launch && seq_ff != SEQ_CMD;
    wire        bad_code  = launch && seq_ff == SEQ_CMD && !cmd_legal;
    wire        no_div    = launch && seq_ff == SEQ_CMD && cmd_legal && !div_loaded_ff;
    wire        pviol_set = launch && seq_ff == SEQ_CMD && cmd_legal && div_loaded_ff &&
                            prot_hit;
    wire        good      = launch && seq_ff == SEQ_CMD && cmd_legal && div_loaded_ff &&
                            !prot_hit;
    wire        burst_good = good && cmd_ff == `FCSR_CMD_BURST;
    // a launch while busy waits in the one-entry buffer
    wire        start_now = good && !exec_busy;
    wire        start_pend = pend_ff && exec_done;
    // stop entry kills the running command
    wire        abort     = stop_s && exec_busy;
    wire        seq_break = (arr_cmd && seq_ff != SEQ_IDLE && seq_ff != SEQ_DATA) ||
                            (wr_cmd && seq_ff != SEQ_DATA);
    fcsr_exec #(
        .CYCLES (EXEC_CYCLES)
    ) u_exec (
        .clk     (SYS_CLK),
        .rst_n   (RESETN),
        .start   (start_now || start_pend),
        .abort   (abort),
        .busy_ff (exec_busy),
        .done_ff (exec_done)
    );
    assign S_AXI_AWREADY = !aw_have_ff;
    assign S_AXI_WREADY  = !w_have_ff;
    assign S_AXI_BVALID  = bvalid_ff;
    assign S_AXI_BRESP   = bresp_ff;
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_RVALID  = rvalid_ff;
    assign S_AXI_RDATA   = rdata_ff;
    assign S_AXI_RRESP   = rresp_ff;
    // key addresses go to the comparator while key enable is set
    assign KEY_WRITE     = ARRAY_WE && keyen && in_key;
    assign CMD_BUSY      = exec_busy;
    assign CMD_CODE      = run_cmd_ff;
    assign CMD_ADDR      = run_addr_ff;
    assign SEC_STATE     = sec_ff;
    // input synchronisers
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            stop_sync_ff   <= 2'b00;
            erased_sync_ff <= 2'b00;
            key_meta_ff    <= 1'b0;
            key_sync_ff    <= 1'b0;
        end else begin
            stop_sync_ff   <= {stop_sync_ff[0], STOP_REQ};
            erased_sync_ff <= {erased_sync_ff[0], ARRAY_ERASED};
            key_meta_ff    <= KEY_MATCH;
            key_sync_ff    <= key_meta_ff;
        end
    end
    // axi write channel
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            awaddr_ff  <= 5'h00;
            aw_have_ff <= 1'b0;
            wdata_ff   <= 32'h00000000;
            w_lane0_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `FCSR_OKAY;
        end else begin
            if (S_AXI_AWVALID && !aw_have_ff) begin
                awaddr_ff  <= S_AXI_AWADDR;
                aw_have_ff <= 1'b1;
            end
            if (S_AXI_WVALID && !w_have_ff) begin
                wdata_ff   <= S_AXI_WDATA;
                w_lane0_ff <= S_AXI_WSTRB[0];
                w_have_ff  <= 1'b1;
            end
            if (wr_go) begin
                aw_have_ff <= 1'b0;
                w_have_ff  <= 1'b0;
                bvalid_ff  <= 1'b1;
                bresp_ff   <= wr_known ? `FCSR_OKAY : `FCSR_SLVERR;
            end else if (bvalid_ff && S_AXI_BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    // axi read channel
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `FCSR_OKAY;
        end else if (S_AXI_ARVALID && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= `FCSR_OKAY;
            case (S_AXI_ARADDR[4:2])
                3'h0:    rdata_ff <= {24'h000000, cfg_ff & `FCSR_CFG_MASK};
                3'h1:    rdata_ff <= {24'h000000, prot_ff};
                3'h2:    rdata_ff <= {24'h000000, bufempty_ff, complete_ff, pviol_ff,
                                      accerr_ff, 1'b0, blank_ff, 2'b00};
                3'h3:    rdata_ff <= {24'h000000, cmd_ff};
                3'h4:    rdata_ff <= {24'h000000, div_loaded_ff, div_ff[6:0]};
                3'h5:    rdata_ff <= {30'h00000000, exec_busy, pend_ff};
                3'h6:    rdata_ff <= {30'h00000000, sec_ff};
                default: begin
                    rdata_ff <= 32'h00000000;
                    rresp_ff <= `FCSR_SLVERR;
                end
            endcase
        end else if (rvalid_ff && S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end
    // configuration, protection, divider
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_ff         <= 8'h00;
            prot_ff        <= 8'h00;
            prot_loaded_ff <= 1'b0;
            div_ff         <= 8'h00;
            div_loaded_ff  <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_ff <= wdata_ff[7:0] & `FCSR_CFG_MASK;
            end
            // first clock after reset copies the nonvolatile byte
            if (!prot_loaded_ff) begin
                prot_ff        <= NONVOLATILE_PROTECTION_BYTE_BYTE;
                prot_loaded_ff <= 1'b1;
            end else if (BDM_PROT_WE) begin
                prot_ff <= BDM_PROT_DATA;
            end else if (wr_prot && !prot_ff[0] && wdata_ff[7:1] < prot_ff[7:1]) begin
                prot_ff[7:1] <= wdata_ff[7:1];
            end
            if (wr_div) begin
                div_ff        <= wdata_ff[7:0];
                div_loaded_ff <= 1'b1;
            end
        end
    end
    // command sequence and status flags
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            seq_ff       <= SEQ_IDLE;
            seq_addr_ff  <= 16'h0000;
            cmd_ff       <= 8'h00;
            bufempty_ff  <= 1'b1;
            complete_ff  <= 1'b1;
            pviol_ff     <= 1'b0;
            accerr_ff    <= 1'b0;
            blank_ff     <= 1'b0;
            pend_ff      <= 1'b0;
            pend_cmd_ff  <= 8'h00;
            pend_addr_ff <= 16'h0000;
            run_cmd_ff   <= 8'h00;
            run_addr_ff  <= 16'h0000;
            sec_ff       <= `FCSR_SEC_RESET;
        end else begin
            if (wr_cmd) begin
                cmd_ff <= wdata_ff[7:0];
            end
            if (seq_break || seq_bad || bad_code || no_div || pviol_set || good || abort) begin
                seq_ff <= SEQ_IDLE;
            end else if (arr_cmd && seq_ff == SEQ_IDLE && bufempty_ff) begin
                seq_ff      <= SEQ_DATA;
                seq_addr_ff <= ARRAY_ADDR;
            end else if (wr_cmd && seq_ff == SEQ_DATA) begin
                seq_ff <= SEQ_CMD;
            end
            if (start_now) begin
                run_cmd_ff  <= cmd_ff;
                run_addr_ff <= seq_addr_ff;
            end else if (start_pend) begin
                run_cmd_ff  <= pend_cmd_ff;
                run_addr_ff <= pend_addr_ff;
            end
            // a valid command launched while the executor is busy parked until it finishes; stop entry drops it
            if (good && exec_busy) begin
                pend_ff      <= 1'b1;
                pend_cmd_ff  <= cmd_ff;
                pend_addr_ff <= seq_addr_ff;
            end else if (start_pend || abort) begin
                pend_ff <= 1'b0;
            end
            if (good && (!burst_good || exec_busy)) begin
                bufempty_ff <= 1'b0;
            end else if ((burst_good && !exec_busy) || start_pend || abort ||
                         (!pend_ff && exec_done)) begin
                bufempty_ff <= 1'b1;
            end
            if (good) begin
                complete_ff <= 1'b0;
            end else if (bufempty_ff && !pend_ff && !exec_busy) begin
                complete_ff <= 1'b1;
            end
            // a set wins over a write-1 clear in the same cycle
            if (pviol_set) begin
                pviol_ff <= 1'b1;
            end else if (wr_stat && wdata_ff[`FCSR_ST_PVIOL]) begin
                pviol_ff <= 1'b0;
            end
            if (seq_bad || bad_code || no_div || seq_break || abort) begin
                accerr_ff <= 1'b1;
            end else if (wr_stat && wdata_ff[`FCSR_ST_ACCERR]) begin
                accerr_ff <= 1'b0;
            end
            if (exec_done && run_cmd_ff == `FCSR_CMD_BLANK && erased_sync_ff[1]) begin
                blank_ff <= 1'b1;
                sec_ff   <= `FCSR_SEC_UNSEC;
            end else if (good) begin
                blank_ff <= 1'b0;
            end
            // key match unsecures until the next reset
            if (key_sync_ff) begin
                sec_ff <= `FCSR_SEC_UNSEC;
            end
        end
    end
endmodule

//--- fcsr_properties.sv
// assertions on the ports of the flash command and status register block
`timescale 1ns/1ps
module fcsr_properties (
    input wire        SYS_CLK,
    input wire        RESETN,
    input wire        ARRAY_WE,
    input wire [15:0] ARRAY_ADDR,
    input wire        KEY_WRITE,
    input wire        CMD_BUSY,
    input wire [7:0]  CMD_CODE,
    input wire [1:0]  SEC_STATE,
    input wire [4:0]  S_AXI_AWADDR,
    input wire        S_AXI_AWVALID,
    input wire        S_AXI_AWREADY,
    input wire [1:0]  S_AXI_BRESP,
    input wire        S_AXI_BVALID,
    input wire        S_AXI_BREADY,
    input wire [4:0]  S_AXI_ARADDR,
    input wire        S_AXI_ARVALID,
    input wire        S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0]  S_AXI_RRESP,
    input wire        S_AXI_RVALID
);
    reg [4:0] rd_addr_ff;
    reg       div_seen_ff;
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // address of the read being answered, divider write seen
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_addr_ff  <= 5'h00;
            div_seen_ff <= 1'b0;
        end else begin
            if (S_AXI_ARVALID && S_AXI_ARREADY)
                rd_addr_ff <= S_AXI_ARADDR;
            if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_AWADDR == 5'h10)
                div_seen_ff <= 1'b1;
        end
    end
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered next cycle");
    resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID
        && $stable(S_AXI_BRESP)) else $error("write response dropped");
    unmapped_err_a: assert property (S_AXI_RVALID && rd_addr_ff >= 5'h1c
        |-> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0) else $error("unmapped read");
    cfg_low_zero_a: assert property (S_AXI_RVALID && rd_addr_ff == 5'h00 |->
        S_AXI_RDATA[4:0] == 5'h00) else $error("config low bits not zero");
    status_zero_a: assert property (S_AXI_RVALID && rd_addr_ff == 5'h08 |->
        S_AXI_RDATA[3] == 1'b0 && S_AXI_RDATA[1:0] == 2'b00) else $error("status bits");
    key_window_a: assert property (KEY_WRITE |-> ARRAY_WE &&
        ARRAY_ADDR[15:3] == 13'h1ff6) else $error("key write outside key window");
    legal_code_a: assert property (CMD_BUSY |-> CMD_CODE inside
        {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("illegal code running");
    div_first_a: assert property (CMD_BUSY && CMD_CODE != 8'h05 |-> div_seen_ff)
        else $error("program or erase before divider write");
    unsecure_stick_a: assert property (SEC_STATE != 2'b00 |->
        SEC_STATE == 2'b10 ##1 SEC_STATE == 2'b10) else $error("security code");
endmodule
bind fcsr_top fcsr_properties fcsr_properties_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .ARRAY_WE(ARRAY_WE), .ARRAY_ADDR(ARRAY_ADDR), .KEY_WRITE(KEY_WRITE), .CMD_BUSY(CMD_BUSY),
    .CMD_CODE(CMD_CODE), .SEC_STATE(SEC_STATE), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID));

//--- test_flash_command_status_regs.sv
// self-checking bench of the flash command and status register block
`timescale 1ns/1ps
module test_flash_command_status_regs;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  nonvolatile_protection_byte = 8'h80;
    reg         bdm_we = 1'b0;
    reg  [7:0]  bdm_d = 8'h00;
    reg         arr_we = 1'b0;
    reg  [15:0] arr_a = 16'h0000;
    reg         erased = 1'b0;
    reg         stop = 1'b0;
    reg         key_m = 1'b0;
    wire [15:0] addr_o;
    reg  [4:0]  awaddr = 5'h00;
    reg  [4:0]  araddr = 5'h00;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [31:0] wdata = 32'h0;
    reg  [3:0]  wstrb = 4'h0;
    wire        awready, wready, bvalid, arready, rvalid, key_wr, busy;
    wire [1:0]  bresp, rresp, sec;
    wire [7:0]  code_o;
    wire [31:0] rdata;
    integer     err_count = 0, tests_run = 0, cyc = 0, seed = 32'hde3387a3, i;
    reg  [31:0] rd_d;
    reg  [1:0]  rd_r, wr_r, sec_m;
    reg  [7:0]  prot_m, st, c;
    reg  [15:0] a;
    reg         blank_m, kw_seen;
    reg  [7:0]  codes [0:5];

    fcsr_top #(.EXEC_CYCLES(16)) fcsr_top_inst (.SYS_CLK(clk), .RESETN(rst_n),
        .NONVOLATILE_PROTECTION_BYTE_BYTE(nonvolatile_protection_byte), .BDM_PROT_WE(bdm_we), .BDM_PROT_DATA(bdm_d), .ARRAY_WE(arr_we),
        .ARRAY_ADDR(arr_a), .ARRAY_ERASED(erased), .KEY_MATCH(key_m), .STOP_REQ(stop),
        .KEY_WRITE(key_wr), .CMD_BUSY(busy), .CMD_CODE(code_o), .CMD_ADDR(addr_o),
        .SEC_STATE(sec),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

    always #12.5 clk = ~clk;

    task close_out;
        begin
            $display("comparisons %0d mismatches %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            err_count = err_count + 1;
            close_out;
        end
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task wr(input [4:0] ad, input [7:0] d);
        reg t_a, t_w, t_b;
        begin
            @(posedge clk);
            awaddr <= ad;
            awvalid <= 1'b1;
            wdata <= {24'h0, d};
            wstrb <= 4'h1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            t_b = 1'b0;
            while (!t_b) begin
                @(negedge clk);
                t_a = awvalid && awready;
                t_w = wvalid && wready;
                t_b = bvalid;
                wr_r = bresp;
                @(posedge clk);
                if (t_a)
                    awvalid <= 1'b0;
                if (t_w)
                    wvalid <= 1'b0;
            end
            bready <= 1'b0;
        end
    endtask

    task rd(input [4:0] ad);
        reg t_r;
        begin
            @(posedge clk);
            araddr <= ad;
            arvalid <= 1'b1;
            rready <= 1'b1;
            t_r = 1'b0;
            while (!t_r) begin
                @(negedge clk);
                t_r = arvalid && arready;
                @(posedge clk);
            end
            arvalid <= 1'b0;
            t_r = 1'b0;
            while (!t_r) begin
                @(negedge clk);
                t_r = rvalid;
                rd_d = rdata;
                rd_r = rresp;
                @(posedge clk);
            end
            rready <= 1'b0;
        end
    endtask

    // one-cycle array write, key strobe sampled once settled
    task pulse(input [15:0] ad);
        begin
            @(posedge clk);
            arr_we <= 1'b1;
            arr_a <= ad;
            #1 kw_seen = key_wr;
            @(posedge clk);
            arr_we <= 1'b0;
        end
    endtask

    task bdm(input [7:0] d);
        begin
            @(posedge clk);
            bdm_we <= 1'b1;
            bdm_d <= d;
            @(posedge clk);
            bdm_we <= 1'b0;
        end
    endtask

    task run(input [15:0] ad, input [7:0] cd);
        begin
            pulse(ad);
            wr(5'h0c, cd);
            wr(5'h08, 8'h80);
        end
    endtask

    task wait_idle;
        integer n;
        begin
            n = 0;
            while (busy !== 1'b0 && n < 200) begin
                @(posedge clk);
                n = n + 1;
            end
            if (busy !== 1'b0)
                err_count = err_count + 1;
            repeat (3) @(posedge clk);
        end
    endtask

    // status after a command finishes, from code, address and protection
    function [7:0] exp_st(input [7:0] cd, input [15:0] ad);
        begin
            if (cd != 8'h05 && cd != 8'h20 && cd != 8'h25 && cd != 8'h40 && cd != 8'h41)
                exp_st = 8'hd0 | {5'h0, blank_m, 2'b00};
            else if (!prot_m[0] && cd != 8'h05 && (cd == 8'h41 || ad[15:9] > prot_m[7:1]))
                exp_st = 8'he0 | {5'h0, blank_m, 2'b00};
            else
                exp_st = (cd == 8'h05 && erased) ? 8'hc4 : 8'hc0;
        end
    endfunction

    initial begin
        codes[0] = 8'h05; codes[1] = 8'h20; codes[2] = 8'h25;
        codes[3] = 8'h40; codes[4] = 8'h41; codes[5] = 8'h9a;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        prot_m = nonvolatile_protection_byte;
        blank_m = 1'b0;
        sec_m = 2'b00;
        rd(5'h04); check(rd_d, {24'h0, nonvolatile_protection_byte});
        rd(5'h08); check(rd_d, 32'hc0);
        rd(5'h1c); check({30'h0, rd_r}, 32'h2);
        wr(5'h1c, 8'h00); check({30'h0, wr_r}, 32'h2);
        for (i = 0; i < 4; i = i + 1) begin
            c = $random(seed);
            wr(5'h00, c);
            check({30'h0, wr_r}, 32'h0);
            rd(5'h00); check(rd_d, {24'h0, c & 8'he0});
        end
        wr(5'h00, 8'h20);
        pulse(16'hffb3); check(kw_seen, 1'b1);
        wr(5'h00, 8'h00);
        pulse(16'hffb5); check(kw_seen, 1'b0);
        wr(5'h0c, 8'h20);
        wr(5'h08, 8'h80);
        rd(5'h08); check(rd_d, 32'hd0);
        wr(5'h08, 8'h10);
        wr(5'h08, 8'h00);
        rd(5'h08); check(rd_d, 32'hc0);
        wr(5'h08, 8'h80);
        rd(5'h08); check(rd_d, 32'hd0);
        wr(5'h08, 8'h10);
        rd(5'h10); check(rd_d[7], 1'b0);
        wr(5'h10, $random(seed));
        rd(5'h10); check(rd_d[7], 1'b1);
        wr(5'h04, 8'hff);
        rd(5'h04); check(rd_d, {24'h0, prot_m});
        wr(5'h04, 8'h40);
        prot_m = 8'h40;
        rd(5'h04); check(rd_d, {24'h0, prot_m});
        bdm(8'h81);
        rd(5'h04); check(rd_d, 32'h81);
        wr(5'h04, 8'h00);
        rd(5'h04); check(rd_d, 32'h81);
        bdm(8'h40);
        for (i = 0; i < 12; i = i + 1) begin
            c = codes[i % 6];
            a = $random(seed);
            erased <= $random(seed);
            wr(5'h08, 8'h30);
            repeat (3) @(posedge clk);
            st = exp_st(c, a);
            run(a, c);
            if (st[5:4] == 2'b00) begin
                #1 check({busy, code_o, addr_o}, {1'b1, c, a});
            end
            wait_idle;
            rd(5'h08); check(rd_d, {24'h0, st});
            if (st[5:4] == 2'b00)
                blank_m = st[2];
            if (st == 8'hc4)
                sec_m = 2'b10;
            check(sec, sec_m);
        end
        wr(5'h08, 8'h30);
        run(16'h0100, 8'h25);
        run(16'h0102, 8'h25);
        rd(5'h08); check(rd_d[7], 1'b0);
        wait_idle;
        wait_idle;
        rd(5'h08); check(rd_d, 32'hc0);
        run(16'h0100, 8'h40);
        stop <= 1'b1;
        wait_idle;
        stop <= 1'b0;
        rd(5'h08); check(rd_d, 32'hd0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check(sec, 2'b00);
        rd(5'h04); check(rd_d, {24'h0, nonvolatile_protection_byte});
        rd(5'h10); check(rd_d[7], 1'b0);
        key_m <= 1'b1;
        repeat (4) @(posedge clk);
        key_m <= 1'b0;
        check(sec, 2'b10);
        close_out;
    end
endmodule
